// *** pkg/acc_consts.svh ***
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
// register indices on the plain port
`define ACC_A_SC1 3'h0
`define ACC_A_SC2 3'h1
`define ACC_A_CFG 3'h2
`define ACC_A_RH 3'h3
`define ACC_A_RL 3'h4
`define ACC_A_CVH 3'h5
`define ACC_A_CVL 3'h6
`define ACC_A_MODE 3'h7
// field positions
`define ACC_B_FLAG 7
`define ACC_B_IEN 6
`define ACC_B_CONT 5
`define ACC_B_ACT 7
`define ACC_B_HWT 6
`define ACC_B_CFE 5
`define ACC_B_CGT 4
`define ACC_B_LP 7
`define ACC_B_LS 4
// field values
`define ACC_CH_OFF 5'h1f
`define ACC_RES_8 2'h0
`define ACC_RES_12 2'h1
`define ACC_RES_10 2'h2
`define ACC_CLK_ASYNC 2'h3
`define ACC_RST_8 8'h00
`define ACC_RST_12 12'h000
// conversion length in converter clock ticks
`define ACC_SAMPLE_SHORT 6'h04
`define ACC_SAMPLE_LONG 6'h18
`define ACC_BITS_8 6'h08
`define ACC_BITS_10 6'h0a
`define ACC_BITS_12 6'h0c
// power mode codes on power_mode_i
`define ACC_PM_RUN 2'h0
`define ACC_PM_WAIT 2'h1
`define ACC_PM_STOP3 2'h2
`define ACC_PM_STOP2 2'h3
`endif

// *** pkg/acc_pkg.sv ***
`default_nettype none
package acc_pkg;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_SAMPLE = 2'b01,
		ACC_CONVERT = 2'b11,
		ACC_FINISH = 2'b10
	} acc_state_t;
	typedef struct packed {
		logic low_power_select;
		logic [1:0] clock_divider;
		logic long_sample_select;
		logic [1:0] resolution;
		logic [1:0] input_clock_select;
	} acc_cfg_t;
	typedef struct packed {
		logic hw_trigger_select;
		logic compare_enable;
		logic compare_greater_select;
	} acc_sc2_t;
	typedef struct packed {
		logic complete_irq_enable;
		logic continuous_enable;
		logic [4:0] channel_select;
	} acc_sc1_t;
endpackage
`default_nettype wire

// *** rtl/acc_compare.sv ***
`default_nettype none
`include "acc_consts.svh"
// difference of result and compare value, resolution-aligned
module acc_compare import acc_pkg::*; (
	input wire logic [11:0] sample_i,
	input wire logic [11:0] limit_i,
	input wire logic [1:0] res_i,
	input wire logic enable_i,
	input wire logic greater_i,
	output logic hit_o,
	output logic [11:0] value_o
);
	logic [12:0] diff;
	logic [11:0] mask;

	always_comb begin
		case (res_i)
			`ACC_RES_12: mask = 12'hfff;
			`ACC_RES_10: mask = 12'h3ff;
			default: mask = 12'h0ff;
		endcase
		// RQ1 RQ5 signed difference one bit wider
		diff = {1'b0, sample_i & mask} - {1'b0, limit_i & mask};
		// RQ2 upper limit: result >= compare
		// RQ3 lower limit: result < compare
		hit_o = !enable_i || (greater_i ? !diff[12] : diff[12]);
		// RQ6 RQ24 sign dropped, implied by limit mode
		value_o = enable_i ? (diff[11:0] & mask) : (sample_i & mask);
	end
endmodule
`default_nettype wire

// *** rtl/acc_ctrl.sv ***
// Summary of operation
// RQ1: compare subtracts compare value from result
// RQ2: upper limit completes when result at least compare
// RQ3: lower limit completes when result below compare
// RQ4: completion with enable raises interrupt request
// RQ5: store difference magnitude, drop sign bit; code stores the low bits of the two's-complement difference
// RQ6: sign implied by limit mode, none stored
// RQ7: compare miss leaves flag and results alone
// RQ8: wait mode never aborts running conversion
// RQ9: wait mode accepts hardware and continuous starts
// RQ10: all clock sources usable in wait
// RQ11: wait or stop3 completion sets flag, wakes
// RQ12: stop3 without async clock aborts, keeps results
// RQ13: after that stop3, idle until new trigger
// RQ14: async clock keeps converting through stop3
// RQ15: software clears blocking before stop3 conversions
// RQ16: stop2 entry resets every register
// RQ17: software programs config, then control two, one
// RQ18: config resolution and clock source fields
// RQ19: config low power, divider, long sample
// RQ20: control two active, trigger, compare fields
// RQ21: control one flag, enable, continuous, channel
// RQ22: software reads result high before low
// RQ23: half-read result blocks transfer, flag clear
// RQ24: difference width follows selected resolution
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
`include "acc_consts.svh"
module acc_ctrl import acc_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [1:0] power_mode_i,
	input wire logic hw_trigger_input_i,
	input wire logic alternate_clock_tick_i,
	input wire logic async_conv_clock_tick_i,
	input wire logic [11:0] sample_data_i,
	output logic [4:0] channel_o,
	output logic sampling_o,
	output logic low_power_o,
	output logic irq_o
);
	acc_cfg_t cfg_q;
	acc_sc2_t sc2_q;
	acc_sc1_t sc1_q;
	acc_state_t state_q;
	logic flag_q;
	logic [11:0] result_q;
	logic [11:0] limit_q;
	logic [7:0] rdata_q;
	logic [5:0] cnt_q;
	logic hwt_s1_q, hwt_s2_q, hwt_s3_q;
	logic half_read_q;
	logic [1:0] pm_q;
	logic tick, hit, hw_edge, async_sel, stop2_entry, stop3_abort;
	logic sc1_wr, cfg_wr, start, finish, blocked, transfer, restart;
	logic [5:0] bits_len;
	logic [11:0] cmp_value;

	////////////////////////////////////////////////////////////////////////////
	// RQ10 every clock source stays usable
	acc_tick_gen u_tick (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.src_i(cfg_q.input_clock_select),
		.div_i(cfg_q.clock_divider),
		.alt_tick_i(alternate_clock_tick_i),
		.async_tick_i(async_conv_clock_tick_i),
		.tick_o(tick)
	);

	acc_compare u_cmp (
		.sample_i(sample_data_i),
		.limit_i(limit_q),
		.res_i(cfg_q.resolution),
		.enable_i(sc2_q.compare_enable),
		.greater_i(sc2_q.compare_greater_select),
		.hit_o(hit),
		.value_o(cmp_value)
	);

	////////////////////////////////////////////////////////////////////////////
	// trigger pin crosses in through two flops, edge taken after them
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			hwt_s1_q <= 1'b0;
			hwt_s2_q <= 1'b0;
			hwt_s3_q <= 1'b0;
			pm_q <= `ACC_PM_RUN;
		end else begin
			hwt_s1_q <= hw_trigger_input_i;
			hwt_s2_q <= hwt_s1_q;
			hwt_s3_q <= hwt_s2_q;
			pm_q <= power_mode_i;
		end
	end

	assign async_sel = (cfg_q.input_clock_select == `ACC_CLK_ASYNC);
	// RQ16 stop2 entry reset
	assign stop2_entry = (power_mode_i == `ACC_PM_STOP2) && (pm_q != `ACC_PM_STOP2);
	// RQ12 stop3 abort path
	assign stop3_abort = (power_mode_i == `ACC_PM_STOP3) && (pm_q != `ACC_PM_STOP3) && !async_sel;
	// RQ9 hardware start; edges ignored while busy
	assign hw_edge = hwt_s2_q && !hwt_s3_q && sc2_q.hw_trigger_select && (state_q == ACC_IDLE);
	assign sc1_wr = wr_i && (addr_i == `ACC_A_SC1);
	assign cfg_wr = wr_i && (addr_i inside {`ACC_A_SC2, `ACC_A_CFG, `ACC_A_CVH, `ACC_A_CVL});
	assign start = (sc1_wr && !sc2_q.hw_trigger_select
		&& (wdata_i[4:0] != `ACC_CH_OFF)) || hw_edge;
	assign finish = (state_q == ACC_FINISH);
	// RQ23 half-read blocking in 10 and 12 bit modes
	assign blocked = half_read_q && (cfg_q.resolution != `ACC_RES_8);
	// RQ7 compare miss
	assign transfer = finish && hit && !blocked;
	// blocked hit restarts; single miss stops; continuous repeats
	assign restart = finish && (sc1_q.continuous_enable || (blocked && hit));

	always_comb begin
		case (cfg_q.resolution)
			`ACC_RES_12: bits_len = `ACC_BITS_12;
			`ACC_RES_10: bits_len = `ACC_BITS_10;
			default: bits_len = `ACC_BITS_8;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// RQ8 RQ14 sequencer; wait and async stop3 keep it running
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || stop2_entry || stop3_abort || cfg_wr) begin
			state_q <= ACC_IDLE;
			cnt_q <= 6'h00;
		end else if (start) begin
			// RQ13 after stop3 abort only a fresh trigger restarts
			state_q <= ACC_SAMPLE;
			cnt_q <= cfg_q.long_sample_select ? `ACC_SAMPLE_LONG : `ACC_SAMPLE_SHORT;
		end else if (sc1_wr) begin
			state_q <= ACC_IDLE;
		end else begin
			case (state_q)
				ACC_IDLE: state_q <= ACC_IDLE;
				ACC_SAMPLE: if (tick) begin
					if (cnt_q == 6'h01) begin
						state_q <= ACC_CONVERT;
						cnt_q <= bits_len;
					end else begin
						cnt_q <= cnt_q - 6'h01;
					end
				end
				ACC_CONVERT: if (tick) begin
					if (cnt_q == 6'h01) begin
						state_q <= ACC_FINISH;
					end else begin
						cnt_q <= cnt_q - 6'h01;
					end
				end
				ACC_FINISH: begin
					state_q <= restart ? ACC_SAMPLE : ACC_IDLE;
					cnt_q <= cfg_q.long_sample_select ? `ACC_SAMPLE_LONG : `ACC_SAMPLE_SHORT;
				end
				default: state_q <= ACC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// RQ18 RQ19 RQ20 RQ21 config and control fields
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || stop2_entry) begin
			cfg_q <= acc_cfg_t'(`ACC_RST_8);
			sc2_q <= '0;
			sc1_q <= acc_sc1_t'(`ACC_CH_OFF);
			limit_q <= `ACC_RST_12;
		end else if (wr_i) begin
			case (addr_i)
				`ACC_A_CFG: cfg_q <= acc_cfg_t'(wdata_i);
				`ACC_A_SC2: sc2_q <= acc_sc2_t'(wdata_i[`ACC_B_HWT:`ACC_B_CGT]);
				`ACC_A_SC1: sc1_q <= acc_sc1_t'(wdata_i[`ACC_B_IEN:0]);
				`ACC_A_CVH: limit_q[11:8] <= wdata_i[3:0];
				`ACC_A_CVL: limit_q[7:0] <= wdata_i;
				default: limit_q <= limit_q;
			endcase
		end
	end

	// RQ24 result transfer, width follows resolution
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || stop2_entry) begin
			result_q <= `ACC_RST_12;
		end else if (transfer) begin
			result_q <= cmp_value;
		end
	end

	// flag: set wins over the clearing write
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || stop2_entry) begin
			flag_q <= 1'b0;
		end else if (transfer) begin
			flag_q <= 1'b1;
		end else if (sc1_wr || (rd_i && addr_i == `ACC_A_RL)) begin
			flag_q <= 1'b0;
		end
	end

	// high byte read arms blocking, low byte read releases
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || stop2_entry) begin
			half_read_q <= 1'b0;
		end else if (rd_i && addr_i == `ACC_A_RH) begin
			half_read_q <= 1'b1;
		end else if (rd_i && addr_i == `ACC_A_RL) begin
			half_read_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_q <= `ACC_RST_8;
		end else if (rd_i) begin
			case (addr_i)
				`ACC_A_SC1: rdata_q <= {flag_q, sc1_q};
				`ACC_A_SC2: rdata_q <= {state_q != ACC_IDLE, sc2_q, 4'h0};
				`ACC_A_CFG: rdata_q <= cfg_q;
				`ACC_A_RH: rdata_q <= {4'h0, result_q[11:8]};
				`ACC_A_RL: rdata_q <= result_q[7:0];
				`ACC_A_CVH: rdata_q <= {4'h0, limit_q[11:8]};
				`ACC_A_CVL: rdata_q <= limit_q[7:0];
				default: rdata_q <= {6'h00, pm_q};
			endcase
		end else begin
			rdata_q <= `ACC_RST_8;
		end
	end

	assign rdata_o = rdata_q;
	assign channel_o = sc1_q.channel_select;
	assign sampling_o = (state_q == ACC_SAMPLE);
	assign low_power_o = cfg_q.low_power_select;
	// RQ4 RQ11 level interrupt, also the wake request
	assign irq_o = flag_q && sc1_q.complete_irq_enable;
endmodule
`default_nettype wire

// *** rtl/acc_tick_gen.sv ***
`default_nettype none
`include "acc_consts.svh"
// converter clock tick: source select then divide by 1,2,4,8
module acc_tick_gen import acc_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [1:0] src_i,
	input wire logic [1:0] div_i,
	input wire logic alt_tick_i,
	input wire logic async_tick_i,
	output logic tick_o
);
	logic half_q;
	logic src_tick;
	logic [2:0] cnt_q;
	logic [2:0] lim;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			half_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
		end
	end

	always_comb begin
		case (src_i)
			2'h0: src_tick = 1'b1;
			2'h1: src_tick = half_q;
			2'h2: src_tick = alt_tick_i;
			default: src_tick = async_tick_i;
		endcase
		lim = 3'((4'h1 << div_i) - 4'h1);
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cnt_q <= 3'h0;
		end else if (src_tick) begin
			cnt_q <= (cnt_q >= lim) ? 3'h0 : cnt_q + 3'h1;
		end
	end

	assign tick_o = src_tick && (cnt_q >= lim);
endmodule
`default_nettype wire

// *** verification/acc_ctrl_chk.sv ***
`default_nettype none
module acc_ctrl_chk (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [1:0] power_mode_i,
	input wire logic [4:0] channel_o,
	input wire logic sampling_o,
	input wire logic low_power_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////
	ien_gates_irq_a: assert property (wr_i && addr_i == 3'h0 && !wdata_i[6] |=> !irq_o)
		else $error("irq high with enable clear");
	rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data without read");
	sc2_reserved_a: assert property (rd_i && addr_i == 3'h1 |=> rdata_o[3:0] == 4'h0)
		else $error("reserved bits not zero");
	low_power_a: assert property (wr_i && addr_i == 3'h2 |=> low_power_o == $past(wdata_i[7]))
		else $error("low power bit not taken");
	channel_wr_a: assert property (wr_i && addr_i == 3'h0 |=> channel_o == $past(wdata_i[4:0]))
		else $error("channel not taken");
	// gap cycle without a write keeps the stored value intact
	cfg_back_a: assert property (wr_i && addr_i == 3'h2 ##1 !wr_i ##1 rd_i && addr_i == 3'h2 |=> rdata_o == $past(wdata_i, 3))
		else $error("config readback differs");
	stop2_regs_a: assert property (power_mode_i == 2'h3 && $past(power_mode_i) != 2'h3 |-> ##[1:2] (channel_o == 5'h1f && !low_power_o))
		else $error("registers kept through stop2");
	stop2_irq_a: assert property (power_mode_i == 2'h3 && $past(power_mode_i) != 2'h3 |-> ##[1:2] !irq_o)
		else $error("irq kept through stop2");
	cover property ($rose(irq_o));
	cover property ($rose(sampling_o));
	cover property (power_mode_i == 2'h2 && sampling_o);
endmodule
bind acc_ctrl acc_ctrl_chk u_chk (
	.clk_sys_i(clk_sys_i),
	.reset_i(reset_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.power_mode_i(power_mode_i),
	.channel_o(channel_o),
	.sampling_o(sampling_o),
	.low_power_o(low_power_o),
	.irq_o(irq_o)
);
`default_nettype wire

// *** verification/acc_ctrl_tb_top.sv ***
`default_nettype none
module acc_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic [1:0] pm = 2'h0;
	logic [11:0] smp = 12'h000;
	logic hwt = 1'b0;
	logic atk = 1'b0;
	logic [7:0] rdata_o;
	logic [4:0] channel_o;
	logic sampling_o;
	logic low_power_o;
	logic irq_o;
	int mismatches = 0;
	int n_compared = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	acc_ctrl u_dut (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.power_mode_i(pm),
		.hw_trigger_input_i(hwt),
		.alternate_clock_tick_i(1'b0),
		.async_conv_clock_tick_i(atk),
		.sample_data_i(smp),
		.channel_o(channel_o),
		.sampling_o(sampling_o),
		.low_power_o(low_power_o),
		.irq_o(irq_o)
	);
	////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [11:0] s, input logic [11:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", {4'h0, rdata_o}, {4'h0, e});
	endtask
	// 10-bit, bus clock, compare value 0x200, then one conversion
	task cv(input logic [7:0] sc2, input logic [11:0] s, input logic hit, input logic [11:0] r);
		int n;
		n = 0;
		// config, then control two, then control one
		wr(3'h2, 8'h08);
		wr(3'h5, 8'h02);
		wr(3'h6, 8'h00);
		wr(3'h1, sc2);
		smp <= s;
		wr(3'h0, 8'h41);
		while (irq_o !== 1'b1 && n < 100) begin
			@(posedge clk_sys_i);
			n++;
		end
		#1;
		chk("irq", {11'h000, irq_o}, {11'h000, hit});
		rd(3'h3, {4'h0, r[11:8]});
		rd(3'h4, r[7:0]);
		chk("irq", {11'h000, irq_o}, 12'h000);
	endtask
	// async clock, hardware trigger pin, conversion carried on in stop3
	task hw_stop3;
		int n;
		n = 0;
		wr(3'h2, 8'h0b);
		wr(3'h1, 8'h40);
		wr(3'h0, 8'h41);
		smp <= 12'h555;
		atk <= 1'b1;
		// no half-read pending when stop3 is entered
		pm <= 2'h2;
		@(posedge clk_sys_i);
		hwt <= 1'b1;
		while (irq_o !== 1'b1 && n < 100) begin
			@(posedge clk_sys_i);
			n++;
		end
		hwt <= 1'b0;
		#1;
		chk("irq", {11'h000, irq_o}, 12'h001);
		rd(3'h3, 8'h01);
		rd(3'h4, 8'h55);
		pm <= 2'h0;
		atk <= 1'b0;
	endtask
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd(3'h0, 8'h1f);
		wr(3'h2, 8'h98);
		rd(3'h2, 8'h98);
		chk("lowpow", {11'h000, low_power_o}, 12'h001);
		pm <= 2'h1;
		cv(8'h30, 12'h280, 1'b1, 12'h080);
		pm <= 2'h0;
		cv(8'h20, 12'h080, 1'b1, 12'h280);
		rd(3'h1, 8'h20);
		cv(8'h20, 12'h280, 1'b0, 12'h280);
		cv(8'h30, 12'h200, 1'b1, 12'h000);
		cv(8'h20, 12'h200, 1'b0, 12'h000);
		// a finished conversion here would leave 0x200 behind
		wr(3'h1, 8'h00);
		wr(3'h0, 8'h01);
		pm <= 2'h2;
		repeat (100) @(posedge clk_sys_i);
		pm <= 2'h0;
		repeat (20) @(posedge clk_sys_i);
		#1;
		chk("busy", {11'h000, sampling_o}, 12'h000);
		rd(3'h3, 8'h00);
		rd(3'h4, 8'h00);
		pm <= 2'h3;
		repeat (3) @(posedge clk_sys_i);
		pm <= 2'h0;
		rd(3'h2, 8'h00);
		rd(3'h0, 8'h1f);
		hw_stop3;
		end_sim;
	end
	initial begin
		#40000;
		mismatches++;
		end_sim;
	end
endmodule
`default_nettype wire
